// ### rtl/wxd_decoder.sv
// Command decoder and property store of the weather-band receiver.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Revision bytes follow status on revision command.
// - Write setting stores; read setting returns value.
// - Interrupt flag command returns interrupt status bits.
// - Firmware load opcodes accepted, used only there.
// - Tune request stores frequency, starts tuning.
// - Tune report returns last tune request status.
// - Quality report returns current channel metrics.
// - Alert message report returns decoded alert info.
// - Alert tone report returns tone detection status.
// - Gain report status; gain toggle sets enable.
// - Aux pin three: drive or float, level.
// - Reference frequency range checked, zero disables tracking.
// - Reference prescaler property defaults to one.
// - Volume property defaults to 0x003F.
// - Mute property defaults to unmuted.
// - Lock window limit defaults to 0x000F.
// - Quality interrupt sources disabled after reset.
// - Threshold properties default high 0x7F, low 0.
// - Alert tone interrupt sources disabled after reset.
// - Alert message interrupt sources disabled after reset.
// - Active-low reset holds whole block in reset.
// - Commands taken only while select is low.
// - Every command answers a status byte.
// - Powerdown stops processing, command port stays alive.
// - Reset restores defaults, leaves block powered down.
module wxd_decoder (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  select_n_pin,
    input  wire logic                  cmd_valid,
    input  wire wxd_pkg::wxd_cmd_type  cmd,
    input  wire wxd_pkg::wxd_radio_type radio,
    input  wire logic                  resp_rd,
    output logic                       resp_valid,
    output logic [7:0]                 resp_byte,
    output logic                       powered,
    output logic                       tune_start,
    output logic [15:0]                tune_freq,
    output logic                       gain_enable,
    output logic                       tracking_enable,
    output logic                       fw_load_strobe,
    output logic                       aux_output_three,
    output logic                       aux_output_three_oe,
    output logic                       aux_output_two_irq,
    output logic [15:0]                volume,
    output logic [15:0]                mute
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WXD_IDLE = 2'b01,
        WXD_RESP = 2'b10
    } wxd_state_type;

    wxd_state_type state_ff;
    wxd_state_type nxt_state;

    logic [15:0] prop_ff [wxd_pkg::NUM_PROPS];
    logic [7:0]  resp_ff [wxd_pkg::RESP_BYTES];
    logic [3:0]  rd_ptr_ff;
    logic        powered_ff;
    logic        tune_start_ff;
    logic [15:0] tune_freq_ff;
    logic        gain_en_ff;
    logic        aux_oe_ff;
    logic        aux_lvl_ff;
    logic        fw_ff;
    logic        irq_ff;
    logic        track_ff;
    logic        resp_valid_ff;
    logic [7:0]  resp_byte_ff;

    wire [7:0]  op       = cmd.opcode;
    wire [15:0] arg_id   = cmd.args[47:32];
    wire [15:0] arg_val  = cmd.args[31:16];
    wire        take     = cmd_valid && !select_n_pin
                           && state_ff == WXD_IDLE;
    wire        op_pwr   = op == wxd_pkg::OP_POWER_UP;
    wire        op_known = op_pwr || op == wxd_pkg::OP_READ_REV
                        || op == wxd_pkg::OP_POWER_DOWN
                        || op == wxd_pkg::OP_WRITE_SETTING
                        || op == wxd_pkg::OP_READ_SETTING
                        || op == wxd_pkg::OP_READ_IRQ
                        || op == wxd_pkg::OP_FW_ARGS
                        || op == wxd_pkg::OP_FW_PAYLOAD
                        || op == wxd_pkg::OP_TUNE_REQ
                        || op == wxd_pkg::OP_TUNE_RPT
                        || op == wxd_pkg::OP_QUALITY_RPT
                        || op == wxd_pkg::OP_ALERT_MSG_RPT
                        || op == wxd_pkg::OP_TONE_RPT
                        || op == wxd_pkg::OP_GAIN_RPT
                        || op == wxd_pkg::OP_GAIN_TOGGLE
                        || op == wxd_pkg::OP_AUX_CONFIG
                        || op == wxd_pkg::OP_AUX_LEVEL;
    // While powered down only the power-up command executes.
    wire        exec     = take && op_known && (powered_ff || op_pwr);
    wire        is_wr    = exec && op == wxd_pkg::OP_WRITE_SETTING;

    logic [wxd_pkg::NUM_PROPS-1:0] hit;
    logic [15:0] rd_val;
    logic        id_found;
    wire  ref_ok = arg_val == 16'h0000
                   || (arg_val >= wxd_pkg::REF_FREQ_MIN
                       && arg_val <= wxd_pkg::REF_FREQ_MAX);
    wire  wr_ok  = id_found
                   && (!hit[wxd_pkg::IDX_REF_FREQ] || ref_ok);

    always_comb begin
        rd_val   = 16'h0000;
        id_found = 1'b0;
        for (int i = 0; i < wxd_pkg::NUM_PROPS; i++) begin
            hit[i] = arg_id == wxd_pkg::PROP_ID[i];
            if (hit[i]) begin
                rd_val   = prop_ff[i];
                id_found = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Property store
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < wxd_pkg::NUM_PROPS; g++) begin : g_prop
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prop_ff[g] <= wxd_pkg::PROP_RST[g];
                end else if (is_wr && hit[g] && wr_ok) begin
                    prop_ff[g] <= arg_val;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Response assembly
    // ------------------------------------------------------------------
    wire        err_bit = take && !exec
                          || (is_wr && !wr_ok);
    wire [7:0]  status  = {1'b1, err_bit, 5'h00, irq_ff};
    logic [7:0] nxt_resp [wxd_pkg::RESP_BYTES];

    always_comb begin
        for (int i = 0; i < wxd_pkg::RESP_BYTES; i++) begin
            nxt_resp[i] = 8'h00;
        end
        nxt_resp[0] = status;
        if (exec) begin
            case (op)
                wxd_pkg::OP_READ_REV: begin
                    nxt_resp[1] = wxd_pkg::REV_PART;
                    nxt_resp[2] = wxd_pkg::REV_FW;
                end
                wxd_pkg::OP_READ_SETTING: begin
                    nxt_resp[2] = rd_val[15:8];
                    nxt_resp[3] = rd_val[7:0];
                end
                wxd_pkg::OP_READ_IRQ: begin
                    nxt_resp[1] = radio.irq_flags;
                end
                wxd_pkg::OP_TUNE_RPT: begin
                    nxt_resp[1] = radio.tune_valid;
                    nxt_resp[2] = tune_freq_ff[15:8];
                    nxt_resp[3] = tune_freq_ff[7:0];
                    nxt_resp[4] = radio.rssi;
                    nxt_resp[5] = radio.snr;
                end
                wxd_pkg::OP_QUALITY_RPT: begin
                    nxt_resp[4] = radio.rssi;
                    nxt_resp[5] = radio.snr;
                end
                wxd_pkg::OP_ALERT_MSG_RPT: begin
                    nxt_resp[1] = radio.alert_msg;
                end
                wxd_pkg::OP_TONE_RPT: begin
                    nxt_resp[1] = radio.tone;
                end
                wxd_pkg::OP_GAIN_RPT: begin
                    nxt_resp[1] = {7'h00, gain_en_ff};
                    nxt_resp[2] = radio.gain;
                end
                default: begin
                    nxt_resp[1] = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    wire last_rd = resp_rd && rd_ptr_ff == 4'hF;
    wire abort   = select_n_pin && state_ff == WXD_RESP;

    always_comb begin
        case (state_ff)
            WXD_IDLE: nxt_state = take ? WXD_RESP : WXD_IDLE;
            WXD_RESP: nxt_state = (last_rd || abort) ? WXD_IDLE : WXD_RESP;
            default:  nxt_state = WXD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= WXD_IDLE;
            rd_ptr_ff <= 4'h0;
        end else begin
            state_ff  <= nxt_state;
            rd_ptr_ff <= take ? 4'h0 : rd_ptr_ff + {3'h0, resp_rd};
        end
    end

    generate
        for (genvar r = 0; r < wxd_pkg::RESP_BYTES; r++) begin : g_resp
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    resp_ff[r] <= 8'h00;
                end else if (take) begin
                    resp_ff[r] <= nxt_resp[r];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_ff <= 1'b0;
            resp_byte_ff  <= 8'h00;
        end else begin
            resp_valid_ff <= nxt_state == WXD_RESP;
            resp_byte_ff  <= take ? nxt_resp[0]
                           : resp_ff[rd_ptr_ff + {3'h0, resp_rd}];
        end
    end

    // ------------------------------------------------------------------
    // Action registers
    // ------------------------------------------------------------------
    wire do_tune = exec && op == wxd_pkg::OP_TUNE_REQ;
    wire irq_any = |(radio.irq_flags
                     & prop_ff[wxd_pkg::IDX_IRQ_ENABLE][7:0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powered_ff    <= 1'b0;
            tune_start_ff <= 1'b0;
            tune_freq_ff  <= 16'h0000;
            gain_en_ff    <= 1'b1;
            aux_oe_ff     <= 1'b0;
            aux_lvl_ff    <= 1'b0;
            fw_ff         <= 1'b0;
            irq_ff        <= 1'b0;
            track_ff      <= 1'b1;
        end else begin
            if (exec && op_pwr) begin
                powered_ff <= 1'b1;
            end else if (exec && op == wxd_pkg::OP_POWER_DOWN) begin
                powered_ff <= 1'b0;
            end
            tune_start_ff <= do_tune;
            if (do_tune) begin
                tune_freq_ff <= cmd.args[47:32];
            end
            if (exec && op == wxd_pkg::OP_GAIN_TOGGLE) begin
                gain_en_ff <= !cmd.args[48];
            end
            if (exec && op == wxd_pkg::OP_AUX_CONFIG) begin
                aux_oe_ff <= cmd.args[50];
            end
            if (exec && op == wxd_pkg::OP_AUX_LEVEL) begin
                aux_lvl_ff <= cmd.args[50];
            end
            fw_ff  <= exec && (op == wxd_pkg::OP_FW_ARGS
                              || op == wxd_pkg::OP_FW_PAYLOAD);
            irq_ff <= powered_ff && irq_any;
            track_ff <= prop_ff[wxd_pkg::IDX_REF_FREQ] != 16'h0000;
        end
    end

    assign resp_valid          = resp_valid_ff;
    assign resp_byte           = resp_byte_ff;
    assign powered             = powered_ff;
    assign tune_start          = tune_start_ff;
    assign tune_freq           = tune_freq_ff;
    assign gain_enable         = gain_en_ff;
    assign tracking_enable     = track_ff;
    assign fw_load_strobe      = fw_ff;
    assign aux_output_three    = aux_lvl_ff;
    assign aux_output_three_oe = aux_oe_ff;
    assign aux_output_two_irq  = irq_ff;
    assign volume              = prop_ff[wxd_pkg::IDX_VOLUME];
    assign mute                = prop_ff[wxd_pkg::IDX_MUTE];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // The host may wait one cycle before its first read strobe.
    sequence s_rev_taken;
        exec && op == wxd_pkg::OP_READ_REV;
    endsequence
    sequence s_first_pop;
        resp_rd && rd_ptr_ff == 4'h0 && state_ff == WXD_RESP;
    endsequence

    chk_tune_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_tune |=> tune_start && tune_freq == $past(cmd.args[47:32]))
        else $error("tune start missing");
    chk_status_cts: assert property (
        @(posedge clk) disable iff (!rst_n)
        take |=> resp_valid && resp_byte[wxd_pkg::ST_CTS])
        else $error("status byte missing");
    chk_pwr_up: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec && op_pwr |=> powered)
        else $error("power up failed");
    chk_pwr_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !powered && take && !op_pwr |=> !powered && !tune_start)
        else $error("acted while powered down");
    chk_refuse_err: assert property (
        @(posedge clk) disable iff (!rst_n)
        take && !exec |=> resp_byte[wxd_pkg::ST_ERR])
        else $error("refused command without error bit");
    chk_select_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        select_n_pin && state_ff == WXD_IDLE |=> !resp_valid)
        else $error("command taken while deselected");
    chk_aux_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec && op == wxd_pkg::OP_AUX_LEVEL
        |=> aux_output_three == $past(cmd.args[50]))
        else $error("aux level wrong");
    chk_gain_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec && op == wxd_pkg::OP_GAIN_TOGGLE
        |=> gain_enable == !$past(cmd.args[48]))
        else $error("gain enable wrong");
    chk_fw_strobe: assert property (
        @(posedge clk) disable iff (!rst_n)
        fw_load_strobe |-> $past(exec) && ($past(op) == wxd_pkg::OP_FW_ARGS
                          || $past(op) == wxd_pkg::OP_FW_PAYLOAD))
        else $error("spurious firmware strobe");
    chk_rev_resp: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_rev_taken ##[1:2] s_first_pop
        |=> resp_byte == wxd_pkg::REV_PART)
        else $error("revision byte wrong");

endmodule : wxd_decoder
`default_nettype wire

// ### rtl/wxd_pkg.sv
// Package with opcodes, property identifiers, defaults and carrier types.
package wxd_pkg;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_POWER_UP      = 8'h01;
    localparam logic [7:0] OP_READ_REV      = 8'h10;
    localparam logic [7:0] OP_POWER_DOWN    = 8'h11;
    localparam logic [7:0] OP_WRITE_SETTING = 8'h12;
    localparam logic [7:0] OP_READ_SETTING  = 8'h13;
    localparam logic [7:0] OP_READ_IRQ      = 8'h14;
    localparam logic [7:0] OP_FW_ARGS       = 8'h15;
    localparam logic [7:0] OP_FW_PAYLOAD    = 8'h16;
    localparam logic [7:0] OP_TUNE_REQ      = 8'h50;
    localparam logic [7:0] OP_TUNE_RPT      = 8'h52;
    localparam logic [7:0] OP_QUALITY_RPT   = 8'h53;
    localparam logic [7:0] OP_ALERT_MSG_RPT = 8'h54;
    localparam logic [7:0] OP_TONE_RPT      = 8'h55;
    localparam logic [7:0] OP_GAIN_RPT      = 8'h57;
    localparam logic [7:0] OP_GAIN_TOGGLE   = 8'h58;
    localparam logic [7:0] OP_AUX_CONFIG    = 8'h80;
    localparam logic [7:0] OP_AUX_LEVEL     = 8'h81;

    // ------------------------------------------------------------------
    // Property identifiers and defaults
    // ------------------------------------------------------------------
    localparam int NUM_PROPS = 13;
    localparam logic [15:0] PROP_ID [NUM_PROPS] = '{
        16'h0001, 16'h0201, 16'h0202, 16'h4000, 16'h4001, 16'h5108,
        16'h5200, 16'h5201, 16'h5202, 16'h5203, 16'h5204, 16'h5500,
        16'h5600};
    localparam logic [15:0] PROP_RST [NUM_PROPS] = '{
        16'h0000, 16'h8000, 16'h0001, 16'h003F, 16'h0000, 16'h000F,
        16'h0000, 16'h007F, 16'h0000, 16'h007F, 16'h0000, 16'h0000,
        16'h0000};
    localparam int IDX_IRQ_ENABLE = 0;
    localparam int IDX_REF_FREQ   = 1;
    localparam int IDX_REF_PRESC  = 2;
    localparam int IDX_VOLUME     = 3;
    localparam int IDX_MUTE       = 4;
    localparam logic [15:0] REF_FREQ_MIN = 16'h799A;
    localparam logic [15:0] REF_FREQ_MAX = 16'h8666;

    // ------------------------------------------------------------------
    // Status byte layout and response sizes
    // ------------------------------------------------------------------
    localparam int ST_CTS     = 7;
    localparam int ST_ERR     = 6;
    localparam int RESP_BYTES = 16;
    // Revision bytes: arbitrary neutral values.
    localparam logic [7:0] REV_PART = 8'h5A;
    localparam logic [7:0] REV_FW   = 8'h11;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [55:0] args;
    } wxd_cmd_type;

    typedef struct packed {
        logic [7:0] tone;
        logic [7:0] alert_msg;
        logic [7:0] rssi;
        logic [7:0] snr;
        logic [7:0] tune_valid;
        logic [7:0] gain;
        logic [7:0] irq_flags;
    } wxd_radio_type;

endpackage : wxd_pkg

// ### bench/wxd_host_model.sv
// Host controller model that issues commands and collects responses.
`timescale 1ns/1ps
`default_nettype none
module wxd_host_model (
    input  wire logic            clk,
    output logic                 select_n_pin,
    output logic                 cmd_valid,
    output wxd_pkg::wxd_cmd_type cmd,
    output logic                 resp_rd,
    input  wire logic            resp_valid,
    input  wire logic [7:0]      resp_byte
);
    logic [7:0] rsp [16];
    logic       hung;

    initial begin
        select_n_pin = 1'b1;
        cmd_valid    = 1'b0;
        cmd          = '0;
        resp_rd      = 1'b0;
        hung         = 1'b0;
    end

    // Sends one command, then reads all 16 bytes or aborts after status.
    task automatic run(input logic [7:0] op, input logic [55:0] args,
                       input bit abort);
        int n;
        @(posedge clk);
        select_n_pin <= 1'b0;
        cmd_valid    <= 1'b1;
        cmd          <= {op, args};
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd       <= ~{op, args};
        #1;
        for (n = 0; n < 8 && resp_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (resp_valid !== 1'b1) hung = 1'b1;
        rsp[0] = resp_byte;
        if (abort) begin
            @(posedge clk);
            select_n_pin <= 1'b1;
        end else begin
            @(posedge clk);
            resp_rd <= 1'b1;
            for (n = 1; n < 16; n++) begin
                @(posedge clk);
                #1;
                rsp[n] = resp_byte;
            end
            @(posedge clk);
            resp_rd <= 1'b0;
        end
    endtask : run

    // Pulses a command while the device is not selected.
    task automatic stray(output bit seen);
        @(posedge clk);
        select_n_pin <= 1'b1;
        cmd_valid    <= 1'b1;
        cmd          <= {wxd_pkg::OP_POWER_DOWN, 56'h0};
        @(posedge clk);
        cmd_valid <= 1'b0;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            if (resp_valid !== 1'b0) seen = 1'b1;
        end
    endtask : stray
endmodule : wxd_host_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench of the command decoder and property store.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
    logic                   clk;
    logic                   rst_n;
    logic                   select_n_pin;
    logic                   cmd_valid;
    wxd_pkg::wxd_cmd_type   cmd;
    wxd_pkg::wxd_radio_type radio;
    logic                   resp_rd;
    logic                   resp_valid;
    logic [7:0]             resp_byte;
    logic                   powered;
    logic                   tune_start;
    logic [15:0]            tune_freq;
    logic                   gain_enable;
    logic                   tracking_enable;
    logic                   fw_load_strobe;
    logic                   aux_output_three;
    logic                   aux_output_three_oe;
    logic                   aux_output_two_irq;
    logic [15:0]            volume;
    logic [15:0]            mute;
    int                     err_total;
    int                     n_checks;
    int                     n_tune;
    int                     n_fw;
    bit                     seen;

    wxd_decoder u_wxd_decoder (
        .clk, .rst_n, .select_n_pin, .cmd_valid, .cmd, .radio, .resp_rd,
        .resp_valid, .resp_byte, .powered, .tune_start, .tune_freq,
        .gain_enable, .tracking_enable, .fw_load_strobe, .aux_output_three,
        .aux_output_three_oe, .aux_output_two_irq, .volume, .mute
    );
    wxd_host_model u_wxd_host_model (
        .clk, .select_n_pin, .cmd_valid, .cmd, .resp_rd, .resp_valid,
        .resp_byte
    );

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (tune_start === 1'b1) n_tune++;
        if (fw_load_strobe === 1'b1) n_fw++;
    end

    // ------------------------------------------------------------------
    // Command helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rb(input int i);
        return u_wxd_host_model.rsp[i];
    endfunction : rb
    task automatic go(input logic [7:0] op, input logic [55:0] a);
        u_wxd_host_model.run(op, a, 1'b0);
        if (u_wxd_host_model.hung === 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask : go
    task automatic wr(input logic [15:0] id, input logic [15:0] v);
        go(wxd_pkg::OP_WRITE_SETTING, {8'h00, id, v, 16'h0000});
    endtask : wr
    task automatic rd(input logic [15:0] id);
        go(wxd_pkg::OP_READ_SETTING, {8'h00, id, 32'h0});
    endtask : rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power();
        go(wxd_pkg::OP_READ_REV, '0);
        `CHK(rb(0), 8'hC0)
        `CHK(powered, 1'b0)
        go(wxd_pkg::OP_POWER_UP, '0);
        `CHK(rb(0), 8'h80)
        `CHK(powered, 1'b1)
        go(wxd_pkg::OP_READ_REV, '0);
        `CHK({rb(1), rb(2)}, {wxd_pkg::REV_PART, wxd_pkg::REV_FW})
        $display("test power done");
    endtask : t_power

    task automatic t_defaults();
        logic [15:0] ev [13] = '{16'h0000, 16'h8000, 16'h0001, 16'h003F,
            16'h0000, 16'h000F, 16'h0000, 16'h007F, 16'h0000, 16'h007F,
            16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 13; i++) begin
            rd(wxd_pkg::PROP_ID[i]);
            if (i < 6) `CHK({rb(2), rb(3)}, ev[i])
            else `CHK({rb(2), rb(3)}, ev[i])
        end
        `CHK(volume, 16'h003F)
        `CHK(mute, 16'h0000)
        `CHK(tracking_enable, 1'b1)
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_props();
        logic [15:0] fv [5] = '{16'h799A, 16'h8666, 16'h7999, 16'h8667,
                                16'h0000};
        logic [7:0]  fs [5] = '{8'h80, 8'h80, 8'hC0, 8'hC0, 8'h80};
        logic [15:0] fk [5] = '{16'h799A, 16'h8666, 16'h8666, 16'h8666,
                                16'h0000};
        wr(16'h4000, 16'h0012);
        `CHK(volume, 16'h0012)
        rd(16'h4000);
        `CHK({rb(2), rb(3)}, 16'h0012)
        wr(16'h4001, 16'h0003);
        `CHK(mute, 16'h0003)
        wr(16'h1234, 16'h0001);
        `CHK(rb(0), 8'hC0)
        for (int i = 0; i < 5; i++) begin
            wr(16'h0201, fv[i]);
            `CHK(rb(0), fs[i])
            rd(16'h0201);
            `CHK({rb(2), rb(3)}, fk[i])
        end
        `CHK(tracking_enable, 1'b0)
        $display("test properties done");
    endtask : t_props

    task automatic t_tune();
        int k;
        k = n_tune;
        go(wxd_pkg::OP_TUNE_REQ, {8'h00, 16'h1F40, 32'h0});
        `CHK(n_tune, k + 1)
        `CHK(tune_freq, 16'h1F40)
        go(wxd_pkg::OP_TUNE_RPT, '0);
        `CHK({rb(1), rb(2), rb(3), rb(4), rb(5)}, 40'h01_1F40_2C_17)
        k = n_fw;
        go(wxd_pkg::OP_FW_ARGS, '0);
        go(wxd_pkg::OP_FW_PAYLOAD, '0);
        `CHK(n_fw, k + 2)
        $display("test tune done");
    endtask : t_tune

    task automatic t_reports();
        logic [7:0] op [7] = '{8'h14, 8'h53, 8'h53, 8'h54, 8'h55, 8'h57,
                               8'h57};
        int         pos [7] = '{1, 4, 5, 1, 1, 1, 2};
        logic [7:0] ev [7] = '{8'h24, 8'h2C, 8'h17, 8'h3B, 8'h01, 8'h01,
                               8'h19};
        for (int i = 0; i < 7; i++) begin
            go(op[i], '0);
            `CHK(rb(pos[i]), ev[i])
        end
        go(wxd_pkg::OP_GAIN_TOGGLE, {8'h01, 48'h0});
        `CHK(gain_enable, 1'b0)
        go(wxd_pkg::OP_GAIN_RPT, '0);
        `CHK(rb(1), 8'h00)
        go(wxd_pkg::OP_GAIN_TOGGLE, '0);
        `CHK(gain_enable, 1'b1)
        $display("test reports done");
    endtask : t_reports

    task automatic t_aux();
        go(wxd_pkg::OP_AUX_CONFIG, {8'h04, 48'h0});
        `CHK(aux_output_three_oe, 1'b1)
        go(wxd_pkg::OP_AUX_LEVEL, {8'h04, 48'h0});
        `CHK(aux_output_three, 1'b1)
        go(wxd_pkg::OP_AUX_LEVEL, '0);
        `CHK(aux_output_three, 1'b0)
        wr(16'h0001, 16'h0004);
        `CHK(aux_output_two_irq, 1'b1)
        go(wxd_pkg::OP_READ_IRQ, '0);
        `CHK(rb(0), 8'h81)
        wr(16'h0001, 16'h0000);
        `CHK(aux_output_two_irq, 1'b0)
        $display("test aux pins done");
    endtask : t_aux

    task automatic t_refuse();
        go(8'h33, '0);
        `CHK(rb(0), 8'hC0)
        u_wxd_host_model.stray(seen);
        `CHK(seen, 1'b0)
        `CHK(powered, 1'b1)
        u_wxd_host_model.run(wxd_pkg::OP_READ_REV, '0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        `CHK(resp_valid, 1'b0)
        go(wxd_pkg::OP_READ_REV, '0);
        `CHK(rb(1), wxd_pkg::REV_PART)
        $display("test refusals done");
    endtask : t_refuse

    task automatic t_reset_mid();
        wr(16'h4000, 16'h0005);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(volume, 16'h003F)
        `CHK(resp_valid, 1'b0)
        `CHK(powered, 1'b0)
        @(posedge clk);
        rst_n <= 1'b1;
        go(wxd_pkg::OP_READ_REV, '0);
        `CHK(rb(0), 8'hC0)
        go(wxd_pkg::OP_POWER_UP, '0);
        rd(16'h4000);
        `CHK({rb(2), rb(3)}, 16'h003F)
        $display("test mid-run reset done");
    endtask : t_reset_mid

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        radio = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        radio <= '{tone: 8'h01, alert_msg: 8'h3B, rssi: 8'h2C, snr: 8'h17,
                   tune_valid: 8'h01, gain: 8'h19, irq_flags: 8'h24};
        t_power();
        t_defaults();
        t_props();
        t_tune();
        t_reports();
        t_aux();
        t_refuse();
        t_reset_mid();
        end_sim();
    end
endmodule : tb
`default_nettype wire
